/* File: hdl/msc_config_regs.sv */
/*
 * Configuration register bank of a gyroscope and accelerometer path,
 * with the derived sensing settings and the output sample strobes.
 * Assumes an APB master on core_clk and sensor logic that reads cfg.
 */
// Notes on behaviour
// - gyro range 250 to 2000 dps
// - gyro bypass field selects filter or bypass
// - accel range 2, 4, 8, 16 g
// - accel low-power average 4 to 32
// - accel bypass bit gives 4 kHz unfiltered
// - accel filter setting 0-7, 1 kHz
// - output rate divided by one plus divider
// - accel low-power wakes once per output sample
// - gyro cycle bit enables low-power, resets 0
// - gyro low-power average field, resets 000
// - four registers at consecutive indices from 1B
// - gyro filtering from bypass and filter setting
// - gyro low-power ignores gyro filter setting
`timescale 1ns/100ps
module msc_config_regs
    import msc_pkg::*;
#(
    parameter int unsigned P_PERIOD_1K = PERIOD_1K,
    parameter int unsigned P_PERIOD_4K = PERIOD_4K,
    parameter int unsigned P_PERIOD_8K = PERIOD_8K
) (
    input  wire logic               core_clk,
    input  wire logic               nrst,
    input  wire logic [APB_AW-1:0]  paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    output msc_cfg_t                cfg,
    output logic                    gyro_sample,
    output logic                    accel_sample,
    output logic                    accel_awake
);

    localparam logic [15:0] PER_1K = 16'(P_PERIOD_1K);
    localparam logic [15:0] PER_4K = 16'(P_PERIOD_4K);
    localparam logic [15:0] PER_8K = 16'(P_PERIOD_8K);

    logic [7:0]    rate_div_q;
    logic [7:0]    gyro_filt_q;
    logic [7:0]    gyro_q;
    logic [7:0]    accel_q;
    logic [7:0]    accel_filt_q;
    logic [7:0]    low_power_q;
    logic [7:0]    accel_lp_q;
    logic [7:0]    status_d;
    logic [31:0]   rd_d;
    logic          hit_d;
    logic          setup;
    logic          wr_en;
    msc_cfg_t      cfg_d;
    logic [15:0]   gyro_period;
    logic [15:0]   accel_period;
    logic          gyro_out;
    logic          accel_base;
    logic          accel_out;
    msc_lp_state_t lp_state_q;
    logic [5:0]    lp_cnt_q;

    // APB: zero-wait, answer in the cycle after setup
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready & pwrite & ~pslverr;

    always_comb begin
        rd_d  = 32'h0000_0000;
        hit_d = 1'b1;
        case (paddr)
            ADDR_RATE_DIV:   rd_d[7:0] = rate_div_q;
            ADDR_GYRO_FILT:  rd_d[7:0] = gyro_filt_q;
            ADDR_GYRO:       rd_d[7:0] = gyro_q;
            ADDR_ACCEL:      rd_d[7:0] = accel_q;
            ADDR_ACCEL_FILT: rd_d[7:0] = accel_filt_q;
            ADDR_LOW_POWER:  rd_d[7:0] = low_power_q;
            ADDR_ACCEL_LP:   rd_d[7:0] = accel_lp_q;
            ADDR_STATUS:     rd_d[7:0] = status_d;
            default:         hit_d     = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~hit_d;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_d;
        end
    end

    // Register writes; masks keep reserved bits at zero
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            gyro_q <= RST_REG;
        end else if (wr_en && paddr == ADDR_GYRO) begin
            gyro_q <= pwdata[7:0] & WMASK_GYRO;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            accel_q <= RST_REG;
        end else if (wr_en && paddr == ADDR_ACCEL) begin
            accel_q <= pwdata[7:0] & WMASK_ACCEL;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            accel_filt_q <= RST_REG;
        end else if (wr_en && paddr == ADDR_ACCEL_FILT) begin
            accel_filt_q <= pwdata[7:0] & WMASK_ACCEL_FILT;
        end
    end

    // Lower nibble reserved here; wake-rate field is not kept
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            low_power_q <= RST_REG;
        end else if (wr_en && paddr == ADDR_LOW_POWER) begin
            low_power_q <= pwdata[7:0] & WMASK_LOW_POWER;
        end
    end

    // Shared by both paths; a smaller value acts at the next base tick
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rate_div_q <= RST_REG;
        end else if (wr_en && paddr == ADDR_RATE_DIV) begin
            rate_div_q <= pwdata[7:0] & WMASK_RATE_DIV;
        end
    end

    // Only the filter setting is kept; other bits read zero
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            gyro_filt_q <= RST_REG;
        end else if (wr_en && paddr == ADDR_GYRO_FILT) begin
            gyro_filt_q <= pwdata[7:0] & WMASK_GYRO_FILT;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            accel_lp_q <= RST_REG;
        end else if (wr_en && paddr == ADDR_ACCEL_LP) begin
            accel_lp_q <= pwdata[7:0] & WMASK_ACCEL_LP;
        end
    end

    // Derived sensing settings
    always_comb begin
        cfg_d = '0;
        cfg_d.selftest = {gyro_q[SELFTEST_LSB +: 3], accel_q[SELFTEST_LSB +: 3]};
        cfg_d.gyro_range_select = gyro_q[RANGE_LSB +: 2];
        cfg_d.gyro_fullscale_dps = GYRO_DPS_MIN << gyro_q[RANGE_LSB +: 2];
        cfg_d.gyro_filter_bypass = gyro_q[GBYPASS_LSB +: 2];
        cfg_d.gyro_filter_setting = gyro_filt_q[2:0];
        cfg_d.gyro_lowpower_en = low_power_q[GCYCLE_BIT];
        cfg_d.gyro_lowpower_average = low_power_q[GAVG_LSB +: 3];
        cfg_d.gyro_avg_count = GYRO_AVG_MIN << low_power_q[GAVG_LSB +: 3];
        // Normal filter only with bypass 00 and not cycling
        cfg_d.gyro_filter_active = (gyro_q[GBYPASS_LSB +: 2] == 2'h0)
                                   && !low_power_q[GCYCLE_BIT];
        if (gyro_q[GBYPASS_LSB] || gyro_q[GBYPASS_LSB + 1]) begin
            cfg_d.gyro_rate = GR_32K;
        end else if (low_power_q[GCYCLE_BIT]) begin
            cfg_d.gyro_rate = GR_1K;
        end else if (gyro_filt_q[2:0] == 3'h0 || gyro_filt_q[2:0] == 3'h7) begin
            cfg_d.gyro_rate = GR_8K;
        end else begin
            cfg_d.gyro_rate = GR_1K;
        end
        cfg_d.accel_range_select = accel_q[RANGE_LSB +: 2];
        cfg_d.accel_fullscale_g = ACCEL_G_MIN << accel_q[RANGE_LSB +: 2];
        cfg_d.accel_filter_bypass = accel_filt_q[ABYPASS_BIT];
        cfg_d.accel_filter_setting = accel_filt_q[ASETTING_LSB +: 3];
        cfg_d.accel_lowpower_en = accel_lp_q[ALP_EN_BIT];
        cfg_d.accel_lowpower_average = accel_filt_q[AAVG_LSB +: 2];
        cfg_d.accel_avg_count = ACCEL_AVG_MIN << accel_filt_q[AAVG_LSB +: 2];
        cfg_d.rate_divider = rate_div_q;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cfg <= '0;
        end else begin
            cfg <= cfg_d;
        end
    end

    // Base periods follow the registered settings
    always_comb begin
        case (cfg.gyro_rate)
            GR_32K:  gyro_period = PERIOD_32K;
            GR_8K:   gyro_period = PER_8K;
            default: gyro_period = PER_1K;
        endcase
        // Filtered accel rate is 1 kHz for every filter setting
        accel_period = cfg.accel_filter_bypass ? PER_4K : PER_1K;
    end

    msc_rate_div u_gyro_div (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .period    (gyro_period),
        .divide    (cfg.rate_divider),
        .base_tick (),
        .out_tick  (gyro_out)
    );

    msc_rate_div u_accel_div (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .period    (accel_period),
        .divide    (cfg.rate_divider),
        .base_tick (accel_base),
        .out_tick  (accel_out)
    );

    // Gyro base tick is left unconnected; only the divided tick leaves
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            gyro_sample <= 1'b0;
        end else begin
            gyro_sample <= gyro_out;
        end
    end

    // Accel duty cycle: wake on each output tick, sleep after averaging.
    // A tick during a wake is dropped, so long averages cap the rate.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lp_state_q   <= ACC_SLEEP;
            lp_cnt_q     <= 6'h00;
            accel_awake  <= 1'b0;
            accel_sample <= 1'b0;
        end else begin
            accel_sample <= 1'b0;
            case (lp_state_q)
                ACC_SLEEP: begin
                    lp_cnt_q <= 6'h00;
                    if (!cfg.accel_lowpower_en) begin
                        accel_sample <= accel_out;
                    end else if (accel_out) begin
                        lp_state_q  <= ACC_AWAKE;
                        accel_awake <= 1'b1;
                    end
                end
                ACC_AWAKE: begin
                    if (!cfg.accel_lowpower_en) begin
                        lp_state_q  <= ACC_SLEEP;
                        accel_awake <= 1'b0;
                    end else if (accel_base) begin
                        if (lp_cnt_q >= cfg.accel_avg_count - 6'h01) begin
                            accel_sample <= 1'b1;
                            lp_cnt_q     <= 6'h00;
                            // A tick on the closing edge starts the next wake at once
                            if (!accel_out) begin
                                lp_state_q  <= ACC_SLEEP;
                                accel_awake <= 1'b0;
                            end
                        end else begin
                            lp_cnt_q <= lp_cnt_q + 6'h01;
                        end
                    end
                end
                default: begin
                    lp_state_q  <= ACC_SLEEP;
                    accel_awake <= 1'b0;
                end
            endcase
        end
    end

    // Status: live rate and mode state, read only
    always_comb begin
        status_d      = 8'h00;
        status_d[1:0] = cfg.gyro_rate;
        status_d[2]   = cfg.accel_filter_bypass;
        status_d[3]   = cfg.gyro_lowpower_en;
        status_d[4]   = (lp_state_q == ACC_AWAKE);
        status_d[5]   = cfg.gyro_filter_active;
    end

endmodule // msc_config_regs

/* File: hdl/msc_pkg.sv */
/*
 * Constants, field layouts and carrier types for the motion sensor
 * configuration register bank.
 * Assumes a single 50 MHz core clock and an APB register port.
 */
package msc_pkg;

    // Clock and sensor data rates
    localparam int unsigned CLK_HZ      = 50_000_000;
    localparam int unsigned RATE_1K_HZ  = 1000;
    localparam int unsigned RATE_4K_HZ  = 4000;
    localparam int unsigned RATE_8K_HZ  = 8000;
    localparam int unsigned RATE_32K_HZ = 32000;
    localparam int unsigned PERIOD_1K   = CLK_HZ / RATE_1K_HZ;
    localparam int unsigned PERIOD_4K   = CLK_HZ / RATE_4K_HZ;
    localparam int unsigned PERIOD_8K   = CLK_HZ / RATE_8K_HZ;
    localparam logic [15:0] PERIOD_32K  = 16'(CLK_HZ / RATE_32K_HZ);

    localparam int unsigned APB_AW = 12;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_RATE_DIV   = 8'h19;
    localparam logic [7:0] IDX_GYRO_FILT  = 8'h1A;
    localparam logic [7:0] IDX_GYRO       = 8'h1B;
    localparam logic [7:0] IDX_ACCEL      = 8'h1C;
    localparam logic [7:0] IDX_ACCEL_FILT = 8'h1D;
    localparam logic [7:0] IDX_LOW_POWER  = 8'h1E;
    localparam logic [7:0] IDX_ACCEL_LP   = 8'h20;
    localparam logic [7:0] IDX_STATUS     = 8'h21;

    localparam logic [11:0] ADDR_RATE_DIV   = {2'h0, IDX_RATE_DIV, 2'h0};
    localparam logic [11:0] ADDR_GYRO_FILT  = {2'h0, IDX_GYRO_FILT, 2'h0};
    localparam logic [11:0] ADDR_GYRO       = {2'h0, IDX_GYRO, 2'h0};
    localparam logic [11:0] ADDR_ACCEL      = {2'h0, IDX_ACCEL, 2'h0};
    localparam logic [11:0] ADDR_ACCEL_FILT = {2'h0, IDX_ACCEL_FILT, 2'h0};
    localparam logic [11:0] ADDR_LOW_POWER  = {2'h0, IDX_LOW_POWER, 2'h0};
    localparam logic [11:0] ADDR_ACCEL_LP   = {2'h0, IDX_ACCEL_LP, 2'h0};
    localparam logic [11:0] ADDR_STATUS     = {2'h0, IDX_STATUS, 2'h0};

    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;

    // Writable bits; reserved bits stay zero
    localparam logic [7:0] WMASK_RATE_DIV   = 8'hFF;
    localparam logic [7:0] WMASK_GYRO_FILT  = 8'h07;
    localparam logic [7:0] WMASK_GYRO       = 8'hFB;
    localparam logic [7:0] WMASK_ACCEL      = 8'hF8;
    localparam logic [7:0] WMASK_ACCEL_FILT = 8'h3F;
    localparam logic [7:0] WMASK_LOW_POWER  = 8'hF0;
    localparam logic [7:0] WMASK_ACCEL_LP   = 8'h01;

    // Field positions
    localparam int unsigned SELFTEST_LSB   = 5;
    localparam int unsigned RANGE_LSB      = 3;
    localparam int unsigned GBYPASS_LSB    = 0;
    localparam int unsigned AAVG_LSB       = 4;
    localparam int unsigned ABYPASS_BIT    = 3;
    localparam int unsigned ASETTING_LSB   = 0;
    localparam int unsigned GCYCLE_BIT     = 7;
    localparam int unsigned GAVG_LSB       = 4;
    localparam int unsigned ALP_EN_BIT     = 0;

    // Scale bases
    localparam logic [11:0] GYRO_DPS_MIN   = 12'h0FA;
    localparam logic [4:0]  ACCEL_G_MIN    = 5'h02;
    localparam logic [5:0]  ACCEL_AVG_MIN  = 6'h04;
    localparam logic [7:0]  GYRO_AVG_MIN   = 8'h01;

    typedef enum logic [1:0] {GR_1K, GR_8K, GR_32K} msc_grate_t;

    typedef enum logic {ACC_SLEEP, ACC_AWAKE} msc_lp_state_t;

    typedef struct packed {
        logic [5:0]  selftest;
        logic [1:0]  gyro_range_select;
        logic [11:0] gyro_fullscale_dps;
        logic [1:0]  gyro_filter_bypass;
        logic [2:0]  gyro_filter_setting;
        logic        gyro_filter_active;
        msc_grate_t  gyro_rate;
        logic        gyro_lowpower_en;
        logic [2:0]  gyro_lowpower_average;
        logic [7:0]  gyro_avg_count;
        logic [1:0]  accel_range_select;
        logic [4:0]  accel_fullscale_g;
        logic        accel_filter_bypass;
        logic [2:0]  accel_filter_setting;
        logic        accel_lowpower_en;
        logic [1:0]  accel_lowpower_average;
        logic [5:0]  accel_avg_count;
        logic [7:0]  rate_divider;
    } msc_cfg_t;

endpackage

/* File: hdl/msc_rate_div.sv */
/*
 * Sample strobe generator: base rate tick from a cycle period, then an
 * output tick every (1 + divide) base ticks.
 * Assumes period and divide come from registers on the same clock.
 */
`timescale 1ns/100ps
module msc_rate_div
    import msc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic [15:0] period,
    input  wire logic [7:0]  divide,
    output logic             base_tick,
    output logic             out_tick
);

    logic [15:0] cyc_q;
    logic [7:0]  div_q;
    logic        base_d;

    // Compare with >= so a shorter period written mid-count still wraps
    assign base_d = (cyc_q >= (period - 16'h0001));

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cyc_q     <= 16'h0000;
            base_tick <= 1'b0;
        end else begin
            cyc_q     <= base_d ? 16'h0000 : cyc_q + 16'h0001;
            base_tick <= base_d;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div_q    <= 8'h00;
            out_tick <= 1'b0;
        end else begin
            out_tick <= 1'b0;
            if (base_d) begin
                if (div_q >= divide) begin
                    div_q    <= 8'h00;
                    out_tick <= 1'b1;
                end else begin
                    div_q <= div_q + 8'h01;
                end
            end
        end
    end

endmodule // msc_rate_div

/* File: verif/motion_sensor_config_regs_test.sv */
/* Bench for the config bank: register access, derived fields, strobe spacing.
   Assumes the host model and the bound checker. */
`timescale 1ns/100ps
module motion_sensor_config_regs_test;
    import msc_pkg::*;
    // Short periods keep strobe tests brief
    localparam int T1K = 40;
    localparam int T4K = 10;
    localparam int T8K = 5;
    localparam logic [31:0] MASKS = {WMASK_LOW_POWER, WMASK_ACCEL_FILT, WMASK_ACCEL,
                                     WMASK_GYRO};
    logic              core_clk = 1'b0;
    logic              nrst = 1'b0;
    logic [APB_AW-1:0] paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    msc_cfg_t          cfg;
    logic              gyro_sample;
    logic              accel_sample;
    logic              accel_awake;
    int                num_errors = 0;
    int                checks_done = 0;
    logic [32:0]       exp_q[$];
    logic [31:0]       lfsr_q = 32'hB33BF2D4;

    always #10 core_clk = ~core_clk;

    msc_config_regs #(.P_PERIOD_1K(T1K), .P_PERIOD_4K(T4K), .P_PERIOD_8K(T8K)) dut_u (
        .core_clk(core_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg(cfg), .gyro_sample(gyro_sample),
        .accel_sample(accel_sample), .accel_awake(accel_awake));
    msc_apb_host host_u (
        .core_clk(core_clk), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr));

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic exp_err);
        logic [31:0] r;
        logic        e;
        host_u.xfer(a, 1'b1, {24'h0, d}, r, e);
        check({32'h0, e}, {32'h0, exp_err});
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] exp);
        logic [31:0] r;
        logic        e;
        exp_q.push_back(exp);
        host_u.xfer(a, 1'b0, 32'h0, r, e);
    endtask

    // Spacing of strobes; first two skipped so the new setting has settled
    task automatic gap(input logic acc, input int exp_cycles);
        int n;
        repeat (2) @(posedge core_clk iff (acc ? accel_sample : gyro_sample));
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (!(acc ? accel_sample : gyro_sample));
        check(33'(n), 33'(exp_cycles));
    endtask

    always @(posedge core_clk) begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            check({pslverr, prdata}, exp_q.pop_front());
        end
    end

    initial begin
        // About twice the longest expected run
        #1_000_000;
        num_errors++;
        end_of_test();
    end

    initial begin
        logic [7:0] v;
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(ADDR_GYRO + 12'(4 * i), 33'h0);
            lfsr_q = next_rand(lfsr_q);
            for (int j = 0; j < 2; j++) begin
                v = (j == 0) ? lfsr_q[7:0] : 8'hFF;
                wr(ADDR_GYRO + 12'(4 * i), v, 1'b0);
                rd(ADDR_GYRO + 12'(4 * i), {25'h0, v & MASKS[8 * i +: 8]});
            end
        end
        rd(12'h300, {1'b1, 32'h0});
        wr(12'h300, 8'hFF, 1'b1);
        for (int s = 0; s < 8; s++) begin
            v = 8'(s);
            wr(ADDR_GYRO, {3'h0, v[1:0], 3'h0}, 1'b0);
            wr(ADDR_ACCEL, {3'h0, v[1:0], 3'h0}, 1'b0);
            wr(ADDR_ACCEL_FILT, {2'h0, v[1:0], 4'h0}, 1'b0);
            wr(ADDR_LOW_POWER, {1'b0, v[2:0], 4'h0}, 1'b0);
        end
        wr(ADDR_LOW_POWER, 8'h00, 1'b0);
        wr(ADDR_RATE_DIV, 8'h03, 1'b0);
        rd(ADDR_RATE_DIV, 33'h03);
        wr(ADDR_GYRO_FILT, 8'h00, 1'b0);
        gap(1'b0, 4 * T8K);
        wr(ADDR_GYRO_FILT, 8'h02, 1'b0);
        rd(ADDR_GYRO_FILT, 33'h02);
        gap(1'b0, 4 * T1K);
        wr(ADDR_GYRO_FILT, 8'h00, 1'b0);
        wr(ADDR_LOW_POWER, 8'h80, 1'b0);
        gap(1'b0, 4 * T1K);
        wr(ADDR_LOW_POWER, 8'h00, 1'b0);
        wr(ADDR_GYRO, 8'h01, 1'b0);
        rd(ADDR_STATUS, 33'(GR_32K));
        gap(1'b0, 4 * 1562);
        wr(ADDR_ACCEL_FILT, 8'h08, 1'b0);
        gap(1'b1, 4 * T4K);
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_ACCEL_FILT, 8'(k), 1'b0);
            gap(1'b1, 4 * T1K);
        end
        wr(ADDR_ACCEL_LP, 8'h01, 1'b0);
        rd(ADDR_ACCEL_LP, 33'h01);
        gap(1'b1, 4 * T1K);
        wr(ADDR_LOW_POWER, 8'hF0, 1'b0);
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        rd(ADDR_LOW_POWER, 33'h0);
        repeat (2) @(posedge core_clk);
        end_of_test();
    end
endmodule // motion_sensor_config_regs_test

/* File: verif/msc_apb_host.sv */
/* Host model: APB master doing one transfer per task call.
   Assumes the bench calls xfer from a single process. */
`timescale 1ns/100ps
module msc_apb_host
    import msc_pkg::*;
(
    input  wire logic              core_clk,
    output logic      [APB_AW-1:0] paddr,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic      [31:0]       pwdata,
    input  wire logic              pready,
    input  wire logic [31:0]       prdata,
    input  wire logic              pslverr
);
    initial begin
        {psel, penable, pwrite} = 3'h0;
        paddr = '0;
        pwdata = '0;
    end

    task automatic xfer(input logic [APB_AW-1:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge core_clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge core_clk);
        penable <= 1'b1;
        // No cycle count assumed; the bench watchdog ends a hang
        @(posedge core_clk iff pready);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released address and data lines show the inverse, not a stale value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // msc_apb_host

/* File: verif/msc_config_regs_properties.sv */
/* Port checker for the config bank: APB answer timing, derived fields, strobes.
   Assumes one clock domain; bound to every msc_config_regs instance. */
`timescale 1ns/100ps
module msc_config_regs_checker
    import msc_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire msc_cfg_t    cfg,
    input wire logic        gyro_sample,
    input wire logic        accel_sample,
    input wire logic        accel_awake
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    ready_cause_a: assert property (pready |-> $past(psel && !penable))
        else $error("answer without setup");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error outside access");
    read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    // Derived fields lag reset release by one edge
    gyro_scale_a: assert property ($past(nrst) |->
        cfg.gyro_fullscale_dps == GYRO_DPS_MIN << cfg.gyro_range_select)
        else $error("gyro range wrong");
    accel_scale_a: assert property ($past(nrst) |->
        cfg.accel_fullscale_g == ACCEL_G_MIN << cfg.accel_range_select)
        else $error("accel range wrong");
    accel_avg_a: assert property ($past(nrst) |->
        cfg.accel_avg_count == ACCEL_AVG_MIN << cfg.accel_lowpower_average)
        else $error("accel average wrong");
    gyro_avg_a: assert property ($past(nrst) |->
        cfg.gyro_avg_count == GYRO_AVG_MIN << cfg.gyro_lowpower_average)
        else $error("gyro average wrong");
    bypass_rate_a: assert property ($past(nrst) && cfg.gyro_filter_bypass[0] |->
        cfg.gyro_rate == GR_32K)
        else $error("bypass rate wrong");
    bypass_filt_a: assert property ($past(nrst) && cfg.gyro_filter_bypass != 2'h0 |->
        !cfg.gyro_filter_active)
        else $error("filter active in bypass");
    lp_rate_a: assert property ($past(nrst) && cfg.gyro_lowpower_en &&
        cfg.gyro_filter_bypass == 2'h0 |-> cfg.gyro_rate == GR_1K)
        else $error("low power gyro rate wrong");
    pulse_gap_a: assert property (gyro_sample |=> !gyro_sample [*4])
        else $error("gyro strobes too close");
    wake_end_a: assert property ($fell(accel_awake) && $past(cfg.accel_lowpower_en) |-> accel_sample)
        else $error("wake ended without sample");
endmodule // msc_config_regs_checker

bind msc_config_regs msc_config_regs_checker chk_u (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg(cfg), .gyro_sample(gyro_sample), .accel_sample(accel_sample),
    .accel_awake(accel_awake));
